/* design/intc_pkg.sv */
// Package: constants, register map and carrier types of the interrupt and DMA request block
package intc_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_PAR_IN = 8'h08;
  localparam logic [7:0] ADDR_PAR_OUT = 8'h0C;
  localparam logic [7:0] ADDR_ACC_MAIN = 8'h10;
  localparam logic [7:0] ADDR_ACC_ALT = 8'h14;
  localparam logic [7:0] ADDR_ACC_STORE = 8'h18;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ST_GIM = 0;
  localparam int ST_MASK_LO = 1;
  localparam int ST_FLAG_LO = 4;
  localparam int CT_DMA = 0;
  localparam int CT_WORD = 1;
  localparam int CT_REQ = 2;
  localparam int CT_FLOAT = 3;
  // Source index inside the three-bit mask and flag groups
  localparam int SRC_PAR = 0;
  localparam int SRC_SIN = 1;
  localparam int SRC_SOUT = 2;
  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam int PC_W = 9;
  localparam logic [PC_W-1:0] INT_VECTOR = 9'h1FF;
  localparam logic [4:0] SERIAL_FULL = 5'h10;
  localparam logic [3:0] FLOAT_LOST = 4'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic return_from_interrupt;
    logic return_from_subroutine;
    logic call;
    logic defer;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] call_ret;
  } seq_evt_t;
  typedef struct packed {
    logic int_take;
    logic pc_load;
    logic [PC_W-1:0] pc_addr;
    logic acc_alt_sel;
  } seq_ctl_t;
  typedef struct packed {
    logic ack;
    logic end_n;
    logic f0;
    logic host_writes;
    logic [15:0] data;
  } dma_pin_t;
endpackage : intc_pkg

/* design/ret_stack.sv */
// Two-entry return address stack for calls and interrupts
`timescale 1ns/1ps
module ret_stack #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
  } stk_t;
  stk_t state_reg;
  stk_t state_next;

  // Shift stack; a push beyond the depth drops the oldest entry
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        state_next.ent[i] = state_reg.ent[i-1];
      state_next.ent[0] = push_data;
    end
    else if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        state_next.ent[i] = state_reg.ent[i+1];
      state_next.ent[DEPTH-1] = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign top = state_reg.ent[0];
endmodule : ret_stack

/* design/intc_dma.sv */
// Interrupt logic and parallel-port DMA request handshake with AXI4-Lite registers
//
// Overview of operation
// - Taking an interrupt sets global mask
// - Return from interrupt clears global mask
// - Status write sets or clears global mask
// - Three source masks, 1 masks, 0 enables
// - Completion flags set even while masked
// - Two-deep return stack for calls, interrupts
// - Two accumulators, handler uses alternate one
// - Floating store loses low four mantissa bits
// - Defer entry during repeat, jump, return
// - Entry loads last instruction address
// - Multiply product lost if interrupted; mask
// - Control DMA flag selects DMA mode
// - DMA mode holds until cleared or end
// - Request driven; acknowledge clears, sets flag
// - Input move reasserts request
// - Output read sets flag; write reasserts
// - End with final word clears DMA
// - Byte mode: lower then upper, once per two
// - Three sources on one level
// - Serial flags: sixteen bits, enable trailing edge
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module intc_dma
  import intc_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sequencer side
  input wire intc_pkg::seq_evt_t seq_evt,
  output intc_pkg::seq_ctl_t seq_ctl,
  // Serial port status (same clock)
  input wire logic [4:0] serial_in_count,
  input wire logic serial_out_enable,
  // DMA controller pins
  input wire intc_pkg::dma_pin_t dma_pin,
  output logic transfer_request,
  output logic [DW-1:0] host_data_out,
  output logic host_data_oe
);
  import intc_pkg::*;

  typedef struct packed {
    logic gim;
    logic [2:0] mask;
    logic [2:0] flag;
    logic dma_en;
    logic word_mode;
    logic req;
    logic float_mode;
    logic [DW-1:0] par_in;
    logic [DW-1:0] par_out;
    logic [DW-1:0] acc_main;
    logic [DW-1:0] acc_alt;
    logic in_handler;
    logic take;
    dma_pin_t pin_s1;
    dma_pin_t pin_s2;
    logic ack_d;
    logic serial_out_enable_d;
    logic sin_full_d;
    logic [DW-1:0] hout;
    logic hoe;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [PC_W-1:0] stack_top;
  logic stack_push;
  logic stack_pop;
  logic [PC_W-1:0] push_addr;
  logic int_pending;
  logic ack_rise;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [DW-1:0] acc_active;

  // ------------------------------------------------------------
  // Combinational helpers
  // ------------------------------------------------------------
  // Expand write strobes to a bit mask
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = {8{state_reg.wstrb[b]}};
  end

  // Strobed write value merged over the current contents
  assign do_write = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  assign ack_rise = state_reg.pin_s2.ack && !state_reg.ack_d;
  assign acc_active = state_reg.in_handler ? state_reg.acc_alt : state_reg.acc_main;
  // A flag asks for entry only while its own mask and the global mask are clear
  assign int_pending = |(state_reg.flag & ~state_reg.mask) && !state_reg.gim
    && !seq_evt.defer && !state_reg.take;

  // Stack traffic: interrupt entry or call pushes, either return pops
  assign stack_push = state_reg.take || seq_evt.call;
  assign stack_pop = seq_evt.return_from_interrupt || seq_evt.return_from_subroutine;
  assign push_addr = state_reg.take ? seq_evt.pc : seq_evt.call_ret;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wval = '0;
    // Pins come from another clock domain: two flops before use
    state_next.pin_s1 = dma_pin;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.ack_d = state_reg.pin_s2.ack;
    state_next.serial_out_enable_d = serial_out_enable;
    state_next.sin_full_d = (serial_in_count == SERIAL_FULL);
    state_next.take = int_pending;

    // Software register write: masks, control, move into output register
    if (do_write)
    begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      case (state_reg.awaddr)
        ADDR_STATUS:
        begin
          wval = state_reg.wdata & wmask;
          if (state_reg.wstrb[0])
          begin
            state_next.gim = wval[ST_GIM];
            state_next.mask = wval[ST_MASK_LO +: 3];
            // Writing a one clears a completion flag
            state_next.flag = state_reg.flag & ~wval[ST_FLAG_LO +: 3];
          end
        end
        ADDR_CONTROL:
        begin
          if (state_reg.wstrb[0])
          begin
            state_next.dma_en = state_reg.wdata[CT_DMA];
            state_next.word_mode = state_reg.wdata[CT_WORD];
            state_next.req = state_reg.wdata[CT_REQ];
            state_next.float_mode = state_reg.wdata[CT_FLOAT];
          end
        end
        ADDR_PAR_OUT:
        begin
          // The write itself moves the active accumulator to the output
          state_next.par_out = acc_active;
          if (state_reg.dma_en)
            state_next.req = 1'b1;
        end
        ADDR_ACC_MAIN:
        begin
          wval = (state_reg.wdata & wmask) | ({16'h0000, state_reg.acc_main} & ~wmask);
          state_next.acc_main = wval[DW-1:0];
        end
        ADDR_ACC_ALT:
        begin
          wval = (state_reg.wdata & wmask) | ({16'h0000, state_reg.acc_alt} & ~wmask);
          state_next.acc_alt = wval[DW-1:0];
        end
        default:
          state_next.bresp = RESP_SLVERR;
      endcase
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
    end

    // AXI write channels taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;

    // AXI read: one cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = '0;
      case (s_axi_araddr)
        ADDR_STATUS:
        begin
          state_next.rdata[ST_GIM] = state_reg.gim;
          state_next.rdata[ST_MASK_LO +: 3] = state_reg.mask;
          state_next.rdata[ST_FLAG_LO +: 3] = state_reg.flag;
        end
        ADDR_CONTROL:
        begin
          state_next.rdata[CT_DMA] = state_reg.dma_en;
          state_next.rdata[CT_WORD] = state_reg.word_mode;
          state_next.rdata[CT_REQ] = state_reg.req;
          state_next.rdata[CT_FLOAT] = state_reg.float_mode;
        end
        ADDR_PAR_IN:
        begin
          // Reading the input register moves it into the active accumulator
          state_next.rdata[DW-1:0] = state_reg.par_in;
          if (state_reg.in_handler)
            state_next.acc_alt = state_reg.par_in;
          else
            state_next.acc_main = state_reg.par_in;
          if (state_reg.dma_en)
            state_next.req = 1'b1;
        end
        ADDR_PAR_OUT:
          state_next.rdata[DW-1:0] = state_reg.par_out;
        ADDR_ACC_MAIN:
          state_next.rdata[DW-1:0] = state_reg.acc_main;
        ADDR_ACC_ALT:
          state_next.rdata[DW-1:0] = state_reg.acc_alt;
        ADDR_ACC_STORE:
        begin
          // Image stored to memory; floating format garbles the low mantissa bits
          state_next.rdata[DW-1:0] = acc_active;
          if (state_reg.float_mode)
            state_next.rdata[3:0] = FLOAT_LOST;
        end
        default:
          state_next.rresp = RESP_SLVERR;
      endcase
    end

    // DMA acknowledge edge: move one word or one byte
    if (ack_rise && state_reg.dma_en)
    begin
      if (state_reg.pin_s2.host_writes)
      begin
        if (state_reg.word_mode)
          state_next.par_in = state_reg.pin_s2.data;
        else if (state_reg.pin_s2.f0)
          state_next.par_in[15:8] = state_reg.pin_s2.data[7:0];
        else
          state_next.par_in[7:0] = state_reg.pin_s2.data[7:0];
      end
      // Lower byte keeps the request up; the word ends on the upper byte
      if (state_reg.word_mode || state_reg.pin_s2.f0)
      begin
        state_next.req = 1'b0;
        state_next.flag[SRC_PAR] = 1'b1;
      end
      if (!state_reg.pin_s2.end_n)
        state_next.dma_en = 1'b0;
    end

    // Serial completion events; set wins over a same-cycle clear
    if ((serial_in_count == SERIAL_FULL) && !state_reg.sin_full_d)
      state_next.flag[SRC_SIN] = 1'b1;
    if (state_reg.serial_out_enable_d && !serial_out_enable)
      state_next.flag[SRC_SOUT] = 1'b1;

    // Lane stays driven through a final acknowledge that drops DMA mode
    state_next.hoe = (state_reg.dma_en || state_reg.hoe) && state_reg.pin_s2.ack
      && !state_reg.pin_s2.host_writes;
    if (state_reg.word_mode)
      state_next.hout = state_reg.par_out;
    else
      state_next.hout = {8'h00, state_reg.pin_s2.f0 ? state_reg.par_out[15:8]
        : state_reg.par_out[7:0]};

    // Interrupt entry and return; entry masks over any software write
    if (seq_evt.return_from_interrupt)
    begin
      state_next.gim = 1'b0;
      state_next.in_handler = 1'b0;
    end
    if (state_reg.take)
    begin
      state_next.gim = 1'b1;
      state_next.in_handler = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= '0;
      state_reg.gim <= 1'b1;
      state_reg.mask <= MASK_RESET;
      state_reg.word_mode <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  ret_stack #(
    .W(PC_W),
    .DEPTH(2)
  ) u_stack (
    .clock(clock),
    .srst(srst),
    .push(stack_push),
    .pop(stack_pop),
    .push_data(push_addr),
    .top(stack_top)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign transfer_request = state_reg.req && state_reg.dma_en;
  assign host_data_out = state_reg.hout;
  assign host_data_oe = state_reg.hoe;
  assign seq_ctl.int_take = state_reg.take;
  assign seq_ctl.pc_load = state_reg.take || stack_pop;
  // Entry jumps to the last instruction word, a return to the stack top
  assign seq_ctl.pc_addr = state_reg.take ? INT_VECTOR : stack_top;
  assign seq_ctl.acc_alt_sel = state_reg.in_handler;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_entry;
    state_reg.take;
  endsequence

  take_sets_gim_a: assert property (s_entry |=> state_reg.gim)
    else $error("global mask not set after entry");
  rti_clears_gim_a: assert property (seq_evt.return_from_interrupt && !state_reg.take |=> !state_reg.gim)
    else $error("global mask not cleared by return");
  vector_load_a: assert property (s_entry |-> seq_ctl.pc_load && seq_ctl.pc_addr == INT_VECTOR)
    else $error("entry did not load vector");
  no_take_masked_a: assert property (state_reg.gim || seq_evt.defer |=> !state_reg.take)
    else $error("entry while masked or deferred");
  pending_takes_a: assert property (int_pending |=> state_reg.take)
    else $error("pending request not taken");
  handler_bank_a: assert property (s_entry |=> seq_ctl.acc_alt_sel)
    else $error("handler bank not selected");
  ack_word_a: assert property (ack_rise && state_reg.dma_en && state_reg.word_mode
    |=> !transfer_request && state_reg.flag[SRC_PAR])
    else $error("word acknowledge mishandled");
  lower_byte_a: assert property (ack_rise && state_reg.dma_en && !state_reg.word_mode
    && !state_reg.pin_s2.f0 && state_reg.req |=> state_reg.req)
    else $error("lower byte dropped request");
  end_clears_dma_a: assert property (ack_rise && state_reg.dma_en && !state_reg.pin_s2.end_n
    |=> !state_reg.dma_en)
    else $error("block end left DMA set");
  serial_out_enable_flag_a: assert property ($fell(serial_out_enable) |=> state_reg.flag[SRC_SOUT])
    else $error("serial out flag missed");
  flag_sticky_a: assert property (state_reg.flag[SRC_PAR] && !do_write
    |=> state_reg.flag[SRC_PAR])
    else $error("flag lost without clear");
endmodule : intc_dma

/* dv/dma_host_model.sv */
// Behavioural model of the host-side 16-bit DMA controller
`timescale 1ns/1ps
module dma_host_model
(
  // Clock
  input wire logic clock,
  // Device request and data
  input wire logic transfer_request,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe,
  // Controller pins
  output intc_pkg::dma_pin_t dma_pin
);
  import intc_pkg::*;

  // ----------------------------------------
  // Idle pins
  // ----------------------------------------
  // End mark idles high; no acknowledge outside a transfer
  initial dma_pin = {1'b0, 1'b1, 1'b0, 1'b0, 16'h0000};

  // ----------------------------------------
  // One transfer
  // ----------------------------------------
  // Acknowledge only against a standing request; hold well past the two-flop sync
  task automatic xfer(input logic wr, input logic sel, input logic fin,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    while (transfer_request !== 1'b1) @(posedge clock);
    dma_pin.host_writes <= wr;
    dma_pin.f0 <= sel;
    dma_pin.end_n <= !fin;
    dma_pin.data <= d;
    dma_pin.ack <= 1'b1;
    repeat (6) @(posedge clock);
    // An undriven lane reads back inverted, never a lucky match
    q = host_data_oe ? host_data_out : ~host_data_out;
    dma_pin.ack <= 1'b0;
    dma_pin.end_n <= 1'b1;
    dma_pin.data <= ~d; // Released bus shows no stale word
    @(posedge clock);
  endtask : xfer
endmodule : dma_host_model

/* dv/interrupt_and_dma_request_logic_test.sv */
// Self-checking testbench of the interrupt and DMA request block
`timescale 1ns/1ps
module interrupt_and_dma_request_logic_test;
  import intc_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock;
  logic srst;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  seq_evt_t seq_evt;
  seq_ctl_t seq_ctl;
  logic [4:0] serial_in_count;
  logic serial_out_enable;
  dma_pin_t dma_pin;
  logic transfer_request;
  logic [15:0] host_data_out;
  logic host_data_oe;
  logic [1:0] resp;
  logic [15:0] q;
  int takes;
  logic [8:0] vec;
  int miscompares;
  int total_checks;

  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  intc_dma i_dut (.clock(clock), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .seq_evt(seq_evt), .seq_ctl(seq_ctl),
    .serial_in_count(serial_in_count), .serial_out_enable(serial_out_enable),
    .dma_pin(dma_pin), .transfer_request(transfer_request), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe));
  dma_host_model i_host (.clock(clock), .transfer_request(transfer_request),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .dma_pin(dma_pin));

  // ----------------------------------------
  // Clock and monitors
  // ----------------------------------------
  // Free-running clock, 8 ns period
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Count interrupt entries and keep the vector seen with each
  always @(posedge clock)
    if (seq_ctl.int_take === 1'b1)
    begin
      takes <= takes + 1;
      vec <= seq_ctl.pc_addr;
    end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr)
    begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rchk
  // Serial input word completes while the count is sixteen
  task automatic sin_done();
    serial_in_count <= SERIAL_FULL;
    repeat (2) @(posedge clock);
    serial_in_count <= 5'h00;
    repeat (3) @(posedge clock);
  endtask : sin_done
  // Return pulse; the popped address stands meanwhile
  task automatic ret_pulse(input logic return_from_subroutine, input logic [8:0] ra);
    {seq_evt.return_from_interrupt, seq_evt.return_from_subroutine} <= {!return_from_subroutine, return_from_subroutine};
    @(negedge clock);
    chk("return", {23'h1, ra}, {22'h0, seq_ctl.pc_load, seq_ctl.pc_addr});
    @(posedge clock);
    {seq_evt.return_from_interrupt, seq_evt.return_from_subroutine} <= 2'b00;
    repeat (2) @(posedge clock);
  endtask : ret_pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(ADDR_STATUS, 32'h00000001, "status after reset");
    rchk(ADDR_CONTROL, 32'h00000002, "control after reset");
    rchk(8'h40, 32'h00000000, "unmapped data");
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    $display("reset test done");
  endtask : t_reset
  task automatic t_serial();
    wr(ADDR_STATUS, 32'h00000004);
    sin_done();
    chk("masked take", 32'h0, takes);
    rchk(ADDR_STATUS, 32'h00000024, "flag under mask");
    wr(ADDR_STATUS, 32'h00000000);
    repeat (4) @(posedge clock);
    chk("take count", 32'h1, takes);
    chk("vector", {23'h0, INT_VECTOR}, {23'h0, vec});
    chk("alt accumulator", 32'h1, {31'h0, seq_ctl.acc_alt_sel});
    seq_evt.call <= 1'b1;
    @(posedge clock);
    seq_evt.call <= 1'b0;
    ret_pulse(1'b1, 9'h055);
    rchk(ADDR_STATUS, 32'h00000021, "status in handler");
    wr(ADDR_STATUS, 32'h00000021);
    ret_pulse(1'b0, 9'h0AB);
    rchk(ADDR_STATUS, 32'h00000000, "status after return");
    wr(ADDR_STATUS, 32'h00000008);
    serial_out_enable <= 1'b1;
    repeat (2) @(posedge clock);
    serial_out_enable <= 1'b0;
    repeat (3) @(posedge clock);
    rchk(ADDR_STATUS, 32'h00000048, "output flag");
    chk("masked output take", 32'h1, takes);
    wr(ADDR_STATUS, 32'h00000041);
    $display("serial test done");
  endtask : t_serial
  task automatic t_defer();
    sin_done();
    seq_evt.defer <= 1'b1;
    wr(ADDR_STATUS, 32'h00000000);
    repeat (5) @(posedge clock);
    chk("deferred take", 32'h1, takes);
    seq_evt.defer <= 1'b0;
    repeat (4) @(posedge clock);
    chk("late take", 32'h2, takes);
    wr(ADDR_STATUS, 32'h00000021);
    ret_pulse(1'b0, 9'h0AB);
    wr(ADDR_STATUS, 32'h00000001); // Keep interrupts off for the DMA work
    $display("deferral test done");
  endtask : t_defer
  task automatic t_dma_out();
    wr(ADDR_CONTROL, 32'h00000003);
    wr(ADDR_ACC_MAIN, 32'h00003C96);
    chk("no request yet", 32'h0, {31'h0, transfer_request});
    wr(ADDR_PAR_OUT, 32'h00000000);
    chk("output request", 32'h1, {31'h0, transfer_request});
    i_host.xfer(1'b0, 1'b0, 1'b1, 16'h0000, q);
    chk("host read word", 32'h3C96, {16'h0, q});
    repeat (3) @(posedge clock);
    rchk(ADDR_STATUS, 32'h00000011, "output flag");
    rchk(ADDR_CONTROL, 32'h00000002, "end of block");
    chk("request after end", 32'h0, {31'h0, transfer_request});
    wr(ADDR_STATUS, 32'h00000011);
    $display("dma output test done");
  endtask : t_dma_out
  task automatic t_dma_word();
    wr(ADDR_CONTROL, 32'h00000007);
    chk("word request", 32'h1, {31'h0, transfer_request});
    i_host.xfer(1'b1, 1'b0, 1'b0, 16'hA55A, q);
    repeat (3) @(posedge clock);
    chk("request cleared", 32'h0, {31'h0, transfer_request});
    rchk(ADDR_STATUS, 32'h00000011, "input flag");
    rchk(ADDR_PAR_IN, 32'h0000A55A, "input word");
    @(posedge clock);
    chk("request again", 32'h1, {31'h0, transfer_request});
    rchk(ADDR_CONTROL, 32'h00000007, "mode kept");
    wr(ADDR_STATUS, 32'h00000011);
    $display("dma word test done");
  endtask : t_dma_word
  task automatic t_dma_byte();
    wr(ADDR_CONTROL, 32'h00000005);
    i_host.xfer(1'b1, 1'b0, 1'b0, 16'h0034, q);
    repeat (3) @(posedge clock);
    chk("request after low", 32'h1, {31'h0, transfer_request});
    rchk(ADDR_STATUS, 32'h00000001, "no flag after low");
    i_host.xfer(1'b1, 1'b1, 1'b0, 16'h0012, q);
    repeat (3) @(posedge clock);
    chk("request after high", 32'h0, {31'h0, transfer_request});
    rchk(ADDR_STATUS, 32'h00000011, "flag after high");
    rchk(ADDR_PAR_IN, 32'h00001234, "byte pair");
    wr(ADDR_STATUS, 32'h00000011);
    $display("dma byte test done");
  endtask : t_dma_byte
  task automatic t_float();
    wr(ADDR_CONTROL, 32'h0000000A);
    wr(ADDR_ACC_MAIN, 32'h0000FFFF);
    rchk(ADDR_ACC_STORE, 32'h0000FFF0, "float store");
    rchk(ADDR_ACC_ALT, 32'h00000000, "alt untouched");
    $display("float store test done");
  endtask : t_float

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // A hang ends the run through the same verdict
  initial
  begin
    #40000;
    miscompares++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end
  // Main sequence
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    seq_evt = {4'h0, 9'h0AB, 9'h055};
    serial_in_count = 5'h00;
    serial_out_enable = 1'b0;
    takes = 0;
    vec = 9'h000;
    miscompares = 0;
    total_checks = 0;
    srst = 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_serial();
    t_defer();
    t_dma_out();
    t_dma_word();
    t_dma_byte();
    t_float();
    close_out();
  end
endmodule : interrupt_and_dma_request_logic_test
